// ---- hw/rlps_pkg.sv ----
package rlps_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam logic [13:0] WDOG_CLEAR_ADDR = 14'h3ff0;
    localparam logic [13:0] STATUS_ADDR = 14'h001e;
    localparam int WDOG_CLEAR_BIT = 0;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Status register fields
    localparam int ST_WAIT_BIT = 0;
    localparam int ST_STOP_BIT = 1;
    localparam int ST_STAB_BIT = 2;
    localparam int ST_WDOG_BIT = 3;
    localparam int ST_RST_BIT = 4;

    // ----------------------------------------------------------------
    // Address ranges and vectors
    // ----------------------------------------------------------------
    localparam logic [13:0] ILLEGAL_LO = 14'h0000;
    localparam logic [13:0] ILLEGAL_HI = 14'h001f;
    localparam logic [13:0] RESET_VECTOR = 14'h3ffe;

    // ----------------------------------------------------------------
    // Counts in bus clock cycles
    // ----------------------------------------------------------------
    localparam int STAB_W = 12;
    localparam logic [11:0] STAB_CYCLES = 12'd4064;
    localparam logic [11:0] STAB_LAST = 12'd1;
    localparam logic [2:0] SHORT_RST_CYCLES = 3'd4;
    localparam int WDOG_W = 20;
    localparam logic [19:0] WDOG_TIMEOUT_DEFAULT = 20'h40000;

    // ----------------------------------------------------------------
    // Pin synchroniser lanes
    // ----------------------------------------------------------------
    localparam int SYNC_PINS = 3;
    localparam int PIN_EXT_RST = 0;
    localparam int PIN_LP_RST = 1;
    localparam int PIN_EXT_IRQ = 2;
    localparam logic [2:0] PIN_IDLE = 3'b111;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_STOP,
        MODE_RECOVER
    } rlps_mode_type;

endpackage : rlps_pkg

// ---- hw/rlps_pin_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// Raw pin levels in, settled levels out
interface rlps_pin_if;
    logic [rlps_pkg::SYNC_PINS-1:0] raw;
    logic [rlps_pkg::SYNC_PINS-1:0] clean;
    modport sync_side (input raw, output clean);
    modport user_side (output raw, input clean);
endinterface : rlps_pin_if

`default_nettype wire

// ---- hw/rlps_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module rlps_pin_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    rlps_pin_if.sync_side pins
);

    // ----------------------------------------------------------------
    // Three stage synchroniser per pin
    // ----------------------------------------------------------------
    logic [rlps_pkg::SYNC_PINS-1:0] s1_reg;
    logic [rlps_pkg::SYNC_PINS-1:0] s2_reg;
    logic [rlps_pkg::SYNC_PINS-1:0] s3_reg;
    logic [rlps_pkg::SYNC_PINS-1:0] clean_reg;

    genvar g;
    generate
        for (g = 0; g < rlps_pkg::SYNC_PINS; g++) begin : g_lane
            // Clean level moves only when stages two and three agree
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    s1_reg[g] <= rlps_pkg::PIN_IDLE[g];
                    s2_reg[g] <= rlps_pkg::PIN_IDLE[g];
                    s3_reg[g] <= rlps_pkg::PIN_IDLE[g];
                    clean_reg[g] <= rlps_pkg::PIN_IDLE[g];
                end else begin
                    s1_reg[g] <= pins.raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g]) begin
                        clean_reg[g] <= s3_reg[g];
                    end
                end
            end
        end
    endgenerate

    assign pins.clean = clean_reg;

endmodule : rlps_pin_sync

`default_nettype wire

// ---- hw/rlps_sequencer.sv ----
// Behaviour
// - Low-power reset pin low asserts internal reset and stops processor clocks.
// - After low-power pin release, clocks restart; reset holds for 4064 cycles.
// - Reset stays asserted past the count while any other source is active.
// - Only ends of pin, low-power pin or watchdog resets update the mode.
// - Power-up holds internal reset for 4064 cycles; no brown-out detection.
// - Watchdog timeout without clearing raises internal reset.
// - Watchdog presence is a build option; absent means no watchdog reset.
// - Writing 0 to bit 0 at 3FF0 clears the watchdog counter.
// - Reads at 3FF0 return the user byte, never watchdog state.
// - Watchdog keeps counting during wait mode.
// - Watchdog freezes during stop mode; no timeout while stopped.
// - Stop left by reset clears watchdog and holds it until count ends.
// - Stop left by interrupt lets watchdog count through the recovery count.
// - Opcode fetch from 0000 to 001F raises an illegal-fetch reset.
// - Stop halts oscillator and all processing; state is retained.
// - Stop entry clears pending timer request, timer enables and prescaler.
// - Stop entry clears the CPU interrupt mask.
// - Stop exits only by external interrupt or reset; pending interrupt exits now.
// - Wait suspends the CPU, clocks keep running; any interrupt or reset exits.
// - Wait entry clears the CPU interrupt mask, nothing else.
// - After low-power release count, CPU starts from vector 3FFE/3FFF.
// - Reset sequence starts on the fifth edge after pin release, once the pin synchroniser has settled.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module rlps_sequencer #(
    parameter logic [19:0] WDOG_TIMEOUT = rlps_pkg::WDOG_TIMEOUT_DEFAULT,
    parameter bit WDOG_PRESENT = 1'b1,
    parameter logic [7:0] USER_BYTE = 8'h00
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_EXT_RESET_N,
    input wire logic I_LOW_POWER_RESET_PIN_N,
    input wire logic I_EXT_IRQ_N,
    input wire logic I_IRQ_REQ,
    input wire logic I_STOP_EXEC,
    input wire logic I_WAIT_EXEC,
    input wire logic I_FETCH,
    input wire logic [13:0] I_FETCH_ADDR,
    input wire logic [13:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    output logic O_INTERNAL_RESET,
    output logic O_CLK_RUN,
    output logic O_CPU_HALT,
    output logic O_TIMER_STOP_CLEAR,
    output logic O_IMASK_CLEAR,
    output logic O_MODE_UPDATE,
    output logic O_VECTOR_FETCH,
    output logic [13:0] O_VECTOR_ADDR
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    rlps_pin_if pin_bus ();

    assign pin_bus.raw[rlps_pkg::PIN_EXT_RST] = I_EXT_RESET_N;
    assign pin_bus.raw[rlps_pkg::PIN_LP_RST] = I_LOW_POWER_RESET_PIN_N;
    assign pin_bus.raw[rlps_pkg::PIN_EXT_IRQ] = I_EXT_IRQ_N;

    rlps_pin_sync u_sync (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .pins(pin_bus.sync_side)
    );

    // Active levels of the settled pins
    wire ext_low = !pin_bus.clean[rlps_pkg::PIN_EXT_RST];
    wire lp_low = !pin_bus.clean[rlps_pkg::PIN_LP_RST];
    wire ext_irq = !pin_bus.clean[rlps_pkg::PIN_EXT_IRQ];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rlps_pkg::rlps_mode_type mode_reg;
    rlps_pkg::rlps_mode_type mode_next;
    logic [11:0] stab_cnt_reg;
    logic [11:0] stab_cnt_next;
    logic stab_rst_reg;
    logic stab_rst_next;
    logic stop_rst_reg;
    logic [2:0] short_cnt_reg;
    logic [2:0] short_cnt_next;
    logic cause_mode_reg;
    logic cause_mode_next;
    logic [19:0] wd_cnt_reg;
    logic [19:0] wd_cnt_next;
    logic [7:0] status;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [13:0] a, input logic [13:0] b);
        hit = (a == b);
    endfunction : hit

    wire wd_clear_hit = I_WR && hit(I_ADDR, rlps_pkg::WDOG_CLEAR_ADDR)
        && !I_WDATA[rlps_pkg::WDOG_CLEAR_BIT];
    wire ill_event = I_FETCH && !O_INTERNAL_RESET
        && (I_FETCH_ADDR <= rlps_pkg::ILLEGAL_HI);
    wire wd_event = WDOG_PRESENT && !O_INTERNAL_RESET
        && (mode_reg != rlps_pkg::MODE_STOP) && !wd_clear_hit
        && (wd_cnt_reg == WDOG_TIMEOUT - 20'd1);
    wire stab_nz = (stab_cnt_reg != 12'h000);
    wire short_nz = (short_cnt_reg != 3'h0);

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    // A pin reset taken while stopped also owes the stabilisation count
    wire stop_rst_now = ext_low && ((mode_reg == rlps_pkg::MODE_STOP) || stop_rst_reg);
    wire load_rst = lp_low || stop_rst_now;
    wire load_irq = (mode_reg == rlps_pkg::MODE_STOP) && ext_irq && !load_rst;
    wire rst_next = lp_low || ext_low || short_nz || wd_event || ill_event
        || (stab_nz && stab_rst_reg);
    wire rst_fall = O_INTERNAL_RESET && !rst_next;

    // Stabilisation counter, reloaded every cycle a delayed source holds
    assign stab_cnt_next = (load_rst || load_irq) ? rlps_pkg::STAB_CYCLES
        : stab_nz ? stab_cnt_reg - 12'd1 : 12'h000;
    assign stab_rst_next = load_rst ? 1'b1 : load_irq ? 1'b0 : stab_rst_reg;

    // Short pulse for watchdog and illegal-fetch sources
    assign short_cnt_next = (wd_event || ill_event) ? rlps_pkg::SHORT_RST_CYCLES
        : short_nz ? short_cnt_reg - 3'd1 : 3'h0;

    // Power-on and illegal fetch leave the mode alone
    assign cause_mode_next = rst_fall ? 1'b0
        : (cause_mode_reg || ext_low || lp_low || wd_event);

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    // Held clear in reset, restarts at timeout, frozen in stop, counts in wait and recovery
    assign wd_cnt_next = (O_INTERNAL_RESET || wd_event || wd_clear_hit || !WDOG_PRESENT) ? 20'h00000
        : (mode_reg == rlps_pkg::MODE_STOP) ? wd_cnt_reg
        : wd_cnt_reg + 20'd1;

    // ----------------------------------------------------------------
    // Low-power mode machine
    // ----------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        if (rst_next) begin
            mode_next = rlps_pkg::MODE_RUN;
        end else begin
            unique case (mode_reg)
                rlps_pkg::MODE_RUN: begin
                    if (I_STOP_EXEC && !ext_irq) begin
                        mode_next = rlps_pkg::MODE_STOP;
                    end else if (I_WAIT_EXEC) begin
                        mode_next = rlps_pkg::MODE_WAIT;
                    end
                end
                rlps_pkg::MODE_WAIT: begin
                    if (I_IRQ_REQ || ext_irq) begin
                        mode_next = rlps_pkg::MODE_RUN;
                    end
                end
                rlps_pkg::MODE_STOP: begin
                    if (ext_irq) begin
                        mode_next = rlps_pkg::MODE_RECOVER;
                    end
                end
                rlps_pkg::MODE_RECOVER: begin
                    if (stab_cnt_reg <= rlps_pkg::STAB_LAST) begin
                        mode_next = rlps_pkg::MODE_RUN;
                    end
                end
            endcase
        end
    end

    // Entry side effects; these pulse on stop even with an interrupt pending, though the mode then stays run
    wire run_ok = (mode_reg == rlps_pkg::MODE_RUN) && !rst_next;
    wire stop_entry = run_ok && I_STOP_EXEC;
    wire imask_entry = run_ok && (I_STOP_EXEC || I_WAIT_EXEC);

    // Status word for software
    assign status = {3'b000,
        O_INTERNAL_RESET,
        WDOG_PRESENT,
        stab_nz,
        mode_reg == rlps_pkg::MODE_STOP,
        mode_reg == rlps_pkg::MODE_WAIT};

    // Read data; the clear location never shows watchdog state
    wire [7:0] rdata_next = hit(I_ADDR, rlps_pkg::WDOG_CLEAR_ADDR) ? USER_BYTE
        : hit(I_ADDR, rlps_pkg::STATUS_ADDR) ? status : rlps_pkg::READ_IDLE;

    // ----------------------------------------------------------------
    // Sequencing registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            mode_reg <= rlps_pkg::MODE_RUN;
            stab_cnt_reg <= rlps_pkg::STAB_CYCLES;
            stab_rst_reg <= 1'b1;
            stop_rst_reg <= 1'b0;
            short_cnt_reg <= 3'h0;
            cause_mode_reg <= 1'b0;
            wd_cnt_reg <= 20'h00000;
        end else begin
            mode_reg <= mode_next;
            stab_cnt_reg <= stab_cnt_next;
            stab_rst_reg <= stab_rst_next;
            stop_rst_reg <= stop_rst_now;
            short_cnt_reg <= short_cnt_next;
            cause_mode_reg <= cause_mode_next;
            wd_cnt_reg <= wd_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Clocks only stop for the low-power pin and for stop mode
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_INTERNAL_RESET <= 1'b1;
            O_CLK_RUN <= 1'b1;
            O_CPU_HALT <= 1'b0;
            O_TIMER_STOP_CLEAR <= 1'b0;
            O_IMASK_CLEAR <= 1'b0;
            O_MODE_UPDATE <= 1'b0;
            O_VECTOR_FETCH <= 1'b0;
            O_VECTOR_ADDR <= rlps_pkg::RESET_VECTOR;
            O_RDATA <= rlps_pkg::READ_IDLE;
        end else begin
            O_INTERNAL_RESET <= rst_next;
            O_CLK_RUN <= !(lp_low || mode_next == rlps_pkg::MODE_STOP);
            O_CPU_HALT <= (mode_next != rlps_pkg::MODE_RUN);
            O_TIMER_STOP_CLEAR <= stop_entry;
            O_IMASK_CLEAR <= imask_entry;
            O_MODE_UPDATE <= rst_fall && cause_mode_reg;
            O_VECTOR_FETCH <= rst_fall;
            O_VECTOR_ADDR <= rlps_pkg::RESET_VECTOR;
            O_RDATA <= I_RD ? rdata_next : rlps_pkg::READ_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_lp_hold;
        @(posedge I_CLK) disable iff (I_RST)
        lp_low |=> O_INTERNAL_RESET && !O_CLK_RUN;
    endproperty
    a_lp_hold: assert property (p_lp_hold) else $error("low-power pin did not hold reset");

    property p_stab_restart;
        @(posedge I_CLK) disable iff (I_RST)
        $fell(lp_low) |-> stab_cnt_reg == rlps_pkg::STAB_CYCLES && stab_rst_reg;
    endproperty
    a_stab_restart: assert property (p_stab_restart) else $error("count not full at release");

    property p_stab_hold;
        @(posedge I_CLK) disable iff (I_RST)
        stab_nz && stab_rst_reg |=> O_INTERNAL_RESET;
    endproperty
    a_stab_hold: assert property (p_stab_hold) else $error("reset released during count");

    property p_other_src;
        @(posedge I_CLK) disable iff (I_RST)
        ext_low |=> O_INTERNAL_RESET && !O_VECTOR_FETCH;
    endproperty
    a_other_src: assert property (p_other_src) else $error("pin reset not held");

    property p_mode_keep;
        @(posedge I_CLK) disable iff (I_RST)
        rst_fall && !cause_mode_reg |=> !O_MODE_UPDATE && O_VECTOR_FETCH;
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode update from wrong source");

    property p_wd_timeout;
        @(posedge I_CLK) disable iff (I_RST)
        wd_event |=> O_INTERNAL_RESET && wd_cnt_reg == 20'h00000 ##1 wd_cnt_reg == 20'h00000;
    endproperty
    a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog timeout missed");

    property p_wd_clear;
        @(posedge I_CLK) disable iff (I_RST)
        wd_clear_hit |=> wd_cnt_reg == 20'h00000;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared");

    property p_rd_user;
        @(posedge I_CLK) disable iff (I_RST)
        I_RD && hit(I_ADDR, rlps_pkg::WDOG_CLEAR_ADDR) |=> O_RDATA == USER_BYTE;
    endproperty
    a_rd_user: assert property (p_rd_user) else $error("clear location read wrong");

    property p_wd_freeze;
        @(posedge I_CLK) disable iff (I_RST)
        mode_reg == rlps_pkg::MODE_STOP && !O_INTERNAL_RESET && !wd_clear_hit
            |=> wd_cnt_reg == $past(wd_cnt_reg);
    endproperty
    a_wd_freeze: assert property (p_wd_freeze) else $error("watchdog moved in stop");

    property p_illegal;
        @(posedge I_CLK) disable iff (I_RST)
        ill_event |=> O_INTERNAL_RESET [*4];
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal fetch not reset");

    property p_stop_entry;
        @(posedge I_CLK) disable iff (I_RST)
        stop_entry |=> O_TIMER_STOP_CLEAR && O_IMASK_CLEAR ##1 !O_TIMER_STOP_CLEAR;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop entry effects missing");

    property p_stop_stay;
        @(posedge I_CLK) disable iff (I_RST)
        mode_reg == rlps_pkg::MODE_STOP && !ext_irq && !rst_next |=> mode_reg == rlps_pkg::MODE_STOP;
    endproperty
    a_stop_stay: assert property (p_stop_stay) else $error("stop left without cause");

    property p_wait_clk;
        @(posedge I_CLK) disable iff (I_RST)
        mode_reg == rlps_pkg::MODE_WAIT |-> O_CLK_RUN && O_CPU_HALT;
    endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("wait mode clock wrong");

    property p_vector;
        @(posedge I_CLK) disable iff (I_RST)
        $fell(O_INTERNAL_RESET) |-> O_VECTOR_FETCH && O_VECTOR_ADDR == rlps_pkg::RESET_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("no vector fetch at release");

endmodule : rlps_sequencer

`default_nettype wire

// ---- test/rlps_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// CPU core stand-in: issues stop, wait and opcode fetches
// ----------------------------------------------------------------
module rlps_cpu_model (
    input wire logic i_clk,
    input wire logic i_req_stop,
    input wire logic i_req_wait,
    input wire logic i_req_fetch,
    input wire logic [13:0] i_req_addr,
    input wire logic i_halt,
    input wire logic i_int_reset,
    output logic o_stop,
    output logic o_wait,
    output logic o_fetch,
    output logic [13:0] o_fetch_addr
);
    // A halted or reset core executes nothing, so requests then are dropped
    wire logic run_ok = !i_halt && !i_int_reset;

    initial o_fetch_addr = 14'h0000;

    // Stop is issued whenever requested while running, with no check of the external irq source
    always @(posedge i_clk) begin
        o_stop <= i_req_stop && run_ok;
        o_wait <= i_req_wait && run_ok;
        o_fetch <= i_req_fetch && run_ok;
        // Idle address bus toggles so a stale address never looks valid
        o_fetch_addr <= (i_req_fetch && run_ok) ? i_req_addr : ~o_fetch_addr;
    end
endmodule : rlps_cpu_model

`default_nettype wire

// ---- test/rlps_sequencer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module rlps_sequencer_tb;
    localparam logic [7:0] USER = 8'h5a;
    localparam logic [19:0] WDOG = 20'd256; // Short timeout keeps the run brief
    typedef struct packed {logic [13:0] addr; logic [7:0] data;} rlps_row_type;
    logic I_CLK = 1'b0;
    logic I_RST = 1'b1;
    logic I_EXT_RESET_N = 1'b1;
    logic I_LOW_POWER_RESET_PIN_N = 1'b1;
    logic I_EXT_IRQ_N = 1'b1;
    logic I_IRQ_REQ = 1'b0;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic [13:0] I_ADDR = 14'h0000;
    logic [7:0] I_WDATA = 8'h00;
    logic rq_stop = 1'b0, rq_wait = 1'b0, rq_fetch = 1'b0;
    logic [13:0] rq_addr = 14'h0000;
    logic [7:0] O_RDATA;
    logic [13:0] O_VECTOR_ADDR, f_addr;
    logic O_INTERNAL_RESET, O_CLK_RUN, O_CPU_HALT, O_TIMER_STOP_CLEAR, O_IMASK_CLEAR, O_MODE_UPDATE, O_VECTOR_FETCH;
    logic c_stop, c_wait, c_fetch;
    int n_mismatch = 0, n_compared = 0, n_mode = 0, n_vec = 0, cyc = 0, m0, v0;
    rlps_row_type rows [4] = '{'{14'h3ff0, USER}, '{14'h0100, 8'h00}, '{14'h001e, 8'h08}, '{14'h3fff, 8'h00}};

    rlps_sequencer #(.WDOG_TIMEOUT(WDOG), .WDOG_PRESENT(1'b1), .USER_BYTE(USER)) u_rlps_sequencer (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_EXT_RESET_N(I_EXT_RESET_N),
        .I_LOW_POWER_RESET_PIN_N(I_LOW_POWER_RESET_PIN_N), .I_EXT_IRQ_N(I_EXT_IRQ_N), .I_IRQ_REQ(I_IRQ_REQ),
        .I_STOP_EXEC(c_stop), .I_WAIT_EXEC(c_wait), .I_FETCH(c_fetch), .I_FETCH_ADDR(f_addr),
        .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .O_INTERNAL_RESET(O_INTERNAL_RESET), .O_CLK_RUN(O_CLK_RUN), .O_CPU_HALT(O_CPU_HALT),
        .O_TIMER_STOP_CLEAR(O_TIMER_STOP_CLEAR), .O_IMASK_CLEAR(O_IMASK_CLEAR), .O_MODE_UPDATE(O_MODE_UPDATE),
        .O_VECTOR_FETCH(O_VECTOR_FETCH), .O_VECTOR_ADDR(O_VECTOR_ADDR));
    rlps_cpu_model u_rlps_cpu_model (.i_clk(I_CLK), .i_req_stop(rq_stop), .i_req_wait(rq_wait),
        .i_req_fetch(rq_fetch), .i_req_addr(rq_addr), .i_halt(O_CPU_HALT), .i_int_reset(O_INTERNAL_RESET),
        .o_stop(c_stop), .o_wait(c_wait), .o_fetch(c_fetch), .o_fetch_addr(f_addr));

    // 50 MHz clock
    always #10 I_CLK = ~I_CLK;

    // ----------------------------------------------------------------
    // Pulse tallies and hang guard
    // ----------------------------------------------------------------
    always @(posedge I_CLK) begin
        cyc++;
        if (O_MODE_UPDATE === 1'b1) n_mode++;
        if (O_VECTOR_FETCH === 1'b1) n_vec++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task end_of_test;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task chk_val(input string nm, input logic [13:0] e, input logic [13:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task tick(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask : tick

    task wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask : wr

    task rd(input logic [13:0] a, input logic [7:0] e);
        @(posedge I_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1;
        chk_val("rdata", {6'h00, e}, {6'h00, O_RDATA});
    endtask : rd

    // Kind 0 stop, 1 wait, 2 fetch; the model turns it into an exec pulse
    task cpu(input int k, input logic [13:0] a);
        @(posedge I_CLK);
        rq_stop <= (k == 0);
        rq_wait <= (k == 1);
        rq_fetch <= (k == 2);
        rq_addr <= a;
        @(posedge I_CLK);
        {rq_stop, rq_wait, rq_fetch} <= 3'b000;
    endtask : cpu

    // Bounded wait for the internal reset level
    task wait_rst(input logic v, input int max, input string nm);
        for (int i = 0; i < max && O_INTERNAL_RESET !== v; i++) tick(1);
        chk_bit(nm, v, O_INTERNAL_RESET);
    endtask : wait_rst

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(6);
        I_RST <= 1'b0;
        tick(10);
        chk_bit("por_hold", 1'b1, O_INTERNAL_RESET);
        wait_rst(1'b0, 4100, "por_end");
        tick(2);
        chk_val("por_vec", 14'd1, n_vec[13:0]);
        chk_val("por_mode", 14'd0, n_mode[13:0]);
        chk_val("vec_addr", 14'h3ffe, O_VECTOR_ADDR);
        wr(rlps_pkg::WDOG_CLEAR_ADDR, 8'h00);
        foreach (rows[i]) rd(rows[i].addr, rows[i].data);
        // Wait mode left by an interrupt request
        cpu(1, 14'h0000);
        tick(1);
        chk_bit("wait_imask", 1'b1, O_IMASK_CLEAR);
        chk_bit("wait_tclr", 1'b0, O_TIMER_STOP_CLEAR);
        tick(1);
        chk_bit("wait_halt", 1'b1, O_CPU_HALT);
        chk_bit("wait_clk", 1'b1, O_CLK_RUN);
        @(posedge I_CLK) I_IRQ_REQ <= 1'b1;
        @(posedge I_CLK) I_IRQ_REQ <= 1'b0;
        tick(3);
        chk_bit("wait_exit", 1'b0, O_CPU_HALT);
        // Watchdog still runs in wait mode
        m0 = n_mode;
        cpu(1, 14'h0000);
        wait_rst(1'b1, 300, "wait_wdog");
        wait_rst(1'b0, 10, "wdog_end");
        tick(2);
        chk_val("wdog_mode", m0[13:0] + 14'd1, n_mode[13:0]);
        // Only a zero in bit 0 services the watchdog
        for (int i = 0; i < 3; i++) begin
            wr(rlps_pkg::WDOG_CLEAR_ADDR, 8'h00);
            tick(200);
        end
        chk_bit("fed", 1'b0, O_INTERNAL_RESET);
        wr(rlps_pkg::WDOG_CLEAR_ADDR, 8'h01);
        wait_rst(1'b1, 70, "odd_write");
        wait_rst(1'b0, 10, "odd_end");
        tick(2);
        // Fetch just above and at the top of the I/O range
        m0 = n_mode;
        cpu(2, 14'h0020);
        tick(4);
        chk_bit("fetch_ok", 1'b0, O_INTERNAL_RESET);
        cpu(2, 14'h001f);
        wait_rst(1'b1, 4, "fetch_bad");
        wait_rst(1'b0, 10, "fetch_end");
        tick(2);
        chk_val("fetch_mode", m0[13:0], n_mode[13:0]);
        // Stop with an external interrupt already pending
        wr(rlps_pkg::WDOG_CLEAR_ADDR, 8'h00);
        I_EXT_IRQ_N <= 1'b0;
        tick(6);
        cpu(0, 14'h0000);
        tick(3);
        chk_bit("stop_pend", 1'b1, O_CLK_RUN);
        chk_bit("stop_pend_halt", 1'b0, O_CPU_HALT);
        I_EXT_IRQ_N <= 1'b1;
        tick(6);
        // Stop proper: watchdog frozen, irq exit, watchdog counts recovery
        cpu(0, 14'h0000);
        tick(1);
        chk_bit("stop_tclr", 1'b1, O_TIMER_STOP_CLEAR);
        chk_bit("stop_imask", 1'b1, O_IMASK_CLEAR);
        tick(1);
        chk_bit("stop_clk", 1'b0, O_CLK_RUN);
        tick(400);
        chk_bit("stop_frozen", 1'b0, O_INTERNAL_RESET);
        I_EXT_IRQ_N <= 1'b0;
        tick(8);
        chk_bit("stop_wake", 1'b1, O_CLK_RUN);
        chk_bit("stop_rec", 1'b1, O_CPU_HALT);
        wait_rst(1'b1, 300, "rec_wdog");
        I_EXT_IRQ_N <= 1'b1;
        // Low-power pin, then pin reset outlasting the count
        I_LOW_POWER_RESET_PIN_N <= 1'b0;
        tick(8);
        chk_bit("lp_rst", 1'b1, O_INTERNAL_RESET);
        chk_bit("lp_clk", 1'b0, O_CLK_RUN);
        I_EXT_RESET_N <= 1'b0;
        tick(8);
        I_LOW_POWER_RESET_PIN_N <= 1'b1;
        tick(8);
        chk_bit("lp_clk_on", 1'b1, O_CLK_RUN);
        tick(4000);
        chk_bit("lp_count", 1'b1, O_INTERNAL_RESET);
        tick(200);
        chk_bit("lp_other", 1'b1, O_INTERNAL_RESET);
        m0 = n_mode;
        v0 = n_vec;
        I_EXT_RESET_N <= 1'b1;
        wait_rst(1'b0, 8, "ext_end");
        tick(2);
        chk_val("lp_vec", v0[13:0] + 14'd1, n_vec[13:0]);
        chk_val("lp_mode", m0[13:0] + 14'd1, n_mode[13:0]);
        // Pin reset out of stop owes the full count
        cpu(0, 14'h0000);
        tick(4);
        chk_bit("stop2_clk", 1'b0, O_CLK_RUN);
        I_EXT_RESET_N <= 1'b0;
        tick(8);
        I_EXT_RESET_N <= 1'b1;
        tick(100);
        chk_bit("stop_rst_hold", 1'b1, O_INTERNAL_RESET);
        wait_rst(1'b0, 4100, "stop_rst_end");
        end_of_test();
    end
endmodule : rlps_sequencer_tb

`default_nettype wire
